// >>> include/sdfc_pkg.sv
// constants, types and register map of the serial converter frame control
package sdfc_pkg;

  // frame layout
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam int CODE_W = 16;
  localparam int CODE_MSB = 15;
  localparam int MODE_HI_POS = 17;
  localparam int MODE_LO_POS = 16;
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_BITS - 1);
  localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;

  // power-down exit timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int EXIT_HI_NS = 2500;
  localparam int EXIT_LO_NS = 5000;
  localparam int WAKE_W = 8;
  localparam logic [WAKE_W-1:0] WAKE_HI_CYC = WAKE_W'(EXIT_HI_NS / CLK_PERIOD_NS);
  localparam logic [WAKE_W-1:0] WAKE_LO_CYC = WAKE_W'(EXIT_LO_NS / CLK_PERIOD_NS);

  // wishbone register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STAT_CNT_W = 8;
  localparam logic [ADDR_W-1:0] REG_CODE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h0C;
  localparam int MODE_LIVE_BIT = 2;
  localparam int CTRL_LOWSUP_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_WAKE_BIT = 1;
  localparam int STAT_LOADED_BIT = 2;
  localparam int STAT_VALID_LSB = 8;
  localparam int STAT_ABORT_LSB = 16;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PD_1K = 2'b01,
    MODE_PD_100K = 2'b10,
    MODE_PD_HIZ = 2'b11
  } sdfc_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_HELD = 2'b10
  } sdfc_state_t;

  typedef struct packed {
    sdfc_state_t st;
    logic [FRAME_BITS-1:0] shift;
    logic [CNT_W-1:0] bitCnt;
    logic [CODE_W-1:0] code;
    sdfc_mode_t mode;
    logic loaded;
    logic frameDone;
    logic [WAKE_W-1:0] wakeCnt;
    logic lowSupply;
    logic [STAT_CNT_W-1:0] validCnt;
    logic [STAT_CNT_W-1:0] abortCnt;
    logic syncM;
    logic syncS;
    logic syncP;
    logic sclkM;
    logic sclkS;
    logic sclkP;
    logic dinM;
    logic dinS;
    logic ack;
    logic [DATA_W-1:0] rdData;
  } sdfc_regs_t;

  localparam sdfc_regs_t REGS_RESET = '0;

endpackage

// >>> hdl/sdfc_top.sv
// frame receiver, mode decode and wishbone registers of the serial converter
`timescale 1ns/1ps
`default_nettype none
module sdfc_top
  import sdfc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // serial link pins
  input wire logic frameSyncN,
  input wire logic serClk,
  input wire logic serDin,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // analog section controls
  output logic [CODE_W-1:0] dacCode,
  output logic pwr_mode_hi,
  output logic pwr_mode_lo,
  output logic linearOn,
  output logic ampConnect,
  output logic term1k,
  output logic term100k,
  output logic outputLive
);

  sdfc_regs_t s_q;
  sdfc_regs_t s_d;
  logic syncRise;
  logic syncFall;
  logic sclkFall;
  logic commit;
  logic abortFrame;
  logic wakeStart;
  logic busReq;
  logic [FRAME_BITS-1:0] nxtShift;
  logic [DATA_W-1:0] rdMux;
  sdfc_mode_t newMode;

  // edges seen on the second and third sampling stages
  assign syncRise = s_q.syncS & ~s_q.syncP;
  assign syncFall = ~s_q.syncS & s_q.syncP;
  assign sclkFall = ~s_q.sclkS & s_q.sclkP;
  assign busReq = wb_cyc_i & wb_stb_i;
  assign nxtShift = {s_q.shift[FRAME_BITS-2:0], s_q.dinS};
  assign newMode = sdfc_mode_t'(nxtShift[MODE_HI_POS:MODE_LO_POS]);

  // read mux
  always_comb begin
    rdMux = '0;
    case (wb_adr_i)
      REG_CODE: begin
        rdMux[CODE_W-1:0] = s_q.code;
      end
      REG_MODE: begin
        rdMux[1:0] = s_q.mode;
        rdMux[MODE_LIVE_BIT] = outputLive;
      end
      REG_CTRL: begin
        rdMux[CTRL_LOWSUP_BIT] = s_q.lowSupply;
      end
      REG_STAT: begin
        rdMux[STAT_ACTIVE_BIT] = (s_q.st == ST_SHIFT);
        rdMux[STAT_WAKE_BIT] = (s_q.wakeCnt != '0);
        rdMux[STAT_LOADED_BIT] = s_q.loaded;
        rdMux[STAT_VALID_LSB +: STAT_CNT_W] = s_q.validCnt;
        rdMux[STAT_ABORT_LSB +: STAT_CNT_W] = s_q.abortCnt;
      end
      default: begin
        rdMux = '0;
      end
    endcase
  end

  // next state
  always_comb begin
    s_d = s_q;
    commit = 1'b0;
    abortFrame = 1'b0;
    wakeStart = 1'b0;
    // three-stage sampling of sync and clock, two-stage of data
    s_d.syncM = frameSyncN;
    s_d.syncS = s_q.syncM;
    s_d.syncP = s_q.syncS;
    s_d.sclkM = serClk;
    s_d.sclkS = s_q.sclkM;
    s_d.sclkP = s_q.sclkS;
    s_d.dinM = serDin;
    s_d.dinS = s_q.dinM;
    s_d.frameDone = 1'b0;
    // frame receiver
    case (s_q.st)
      ST_IDLE, ST_HELD: begin
        if (syncFall) begin
          s_d.st = ST_SHIFT;
          s_d.shift = '0;
          s_d.bitCnt = '0;
        end else if (syncRise) begin
          s_d.st = ST_IDLE;
        end
      end
      ST_SHIFT: begin
        if (syncRise) begin
          abortFrame = 1'b1;
          s_d.st = ST_IDLE;
          s_d.shift = '0;
          s_d.bitCnt = '0;
          s_d.abortCnt = s_q.abortCnt + 8'h01;
        end else if (sclkFall) begin
          s_d.shift = nxtShift;
          if (s_q.bitCnt == LAST_BIT) begin
            commit = 1'b1;
            s_d.st = ST_HELD;
            s_d.bitCnt = '0;
          end else begin
            s_d.bitCnt = s_q.bitCnt + 5'h01;
          end
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    // frame execution
    if (commit) begin
      s_d.code = nxtShift[CODE_MSB:0];
      s_d.mode = newMode;
      s_d.loaded = 1'b1;
      s_d.frameDone = 1'b1;
      s_d.validCnt = s_q.validCnt + 8'h01;
    end
    // power-down exit delay
    if (commit && newMode != MODE_NORMAL) begin
      s_d.wakeCnt = '0;
    end else if (commit && s_q.mode != MODE_NORMAL) begin
      wakeStart = 1'b1;
      s_d.wakeCnt = s_q.lowSupply ? WAKE_LO_CYC : WAKE_HI_CYC;
    end else if (s_q.wakeCnt != '0) begin
      s_d.wakeCnt = s_q.wakeCnt - 8'h01;
    end
    // wishbone slave, one wait state
    s_d.ack = busReq & ~s_q.ack;
    if (busReq && !s_q.ack) begin
      s_d.rdData = rdMux;
    end
    if (busReq && s_q.ack && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL) begin
      s_d.lowSupply = wb_dat_i[CTRL_LOWSUP_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_q <= REGS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign wb_dat_o = s_q.rdData;
  assign wb_ack_o = s_q.ack;
  assign dacCode = s_q.code;
  assign pwr_mode_hi = s_q.mode[1];
  assign pwr_mode_lo = s_q.mode[0];
  assign linearOn = (s_q.mode == MODE_NORMAL);
  assign ampConnect = linearOn;
  assign term1k = (s_q.mode == MODE_PD_1K);
  assign term100k = (s_q.mode == MODE_PD_100K);
  assign outputLive = linearOn && (s_q.wakeCnt == '0);

  // checks
  localparam int WakeHiDly = 100;
  localparam int WakeLoDly = 200;

  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence sWakeHiStart;
    wakeStart && !s_q.lowSupply;
  endsequence

  sequence sWakeLoStart;
    wakeStart && s_q.lowSupply;
  endsequence

  sequence sFrameOpen;
    (s_q.st != ST_SHIFT) && syncFall;
  endsequence

  sequence sShiftFall;
    (s_q.st == ST_SHIFT) && !syncRise && sclkFall;
  endsequence

  sequence sFrameCut;
    (s_q.st == ST_SHIFT) && syncRise;
  endsequence

  sequence sBusTake;
    busReq && !s_q.ack;
  endsequence

  sequence sCtrlWrite;
    busReq && s_q.ack && wb_we_i && wb_sel_i[0] && (wb_adr_i == REG_CTRL);
  endsequence

  a_frame_start: assert property (
    sFrameOpen |=> (s_q.st == ST_SHIFT) && (s_q.bitCnt == '0) && (s_q.shift == '0))
    else $error("frame did not open on sync fall");

  a_shift_in: assert property (
    (s_q.st == ST_SHIFT) && !syncRise && sclkFall
      |=> s_q.shift == {$past(s_q.shift[FRAME_BITS-2:0]), $past(s_q.dinS)})
    else $error("serial bit not shifted in");

  a_commit_fields: assert property (
    commit |=> (s_q.code == $past(nxtShift[CODE_MSB:0]))
      && (s_q.mode == $past(nxtShift[MODE_HI_POS:MODE_LO_POS])) && s_q.frameDone)
    else $error("frame fields not loaded");

  a_commit_count: assert property (
    commit |-> (s_q.bitCnt == LAST_BIT) && sclkFall && (s_q.st == ST_SHIFT))
    else $error("frame executed at wrong edge");

  a_abort_keep: assert property (
    (s_q.st == ST_SHIFT) && syncRise
      |=> (s_q.st == ST_IDLE) && (s_q.shift == '0) && $stable(s_q.code) && $stable(s_q.mode))
    else $error("aborted frame changed state");

  a_code_stable: assert property (
    ($changed(s_q.code) || $changed(s_q.mode)) |-> s_q.frameDone)
    else $error("code or mode changed without frame");

  a_zero_until: assert property (
    !s_q.loaded |-> (dacCode == CODE_RESET) && (s_q.mode == MODE_NORMAL))
    else $error("code not zero before first frame");

  a_pd_hold: assert property (
    (s_q.mode != MODE_NORMAL) && !commit |=> $stable(s_q.code))
    else $error("code lost in power-down");

  a_term_decode: assert property (
    (term1k |-> pwr_mode_lo && !pwr_mode_hi) and (term100k |-> pwr_mode_hi && !pwr_mode_lo)
      and (linearOn |-> !term1k && !term100k))
    else $error("termination decode wrong");

  a_wake_hi: assert property (
    sWakeHiStart |=> (!outputLive)[*8] ##[1:WakeHiDly] outputLive)
    else $error("fast power-down exit time wrong");

  a_wake_lo: assert property (
    sWakeLoStart |=> (!outputLive)[*8] ##[WakeHiDly:WakeLoDly] outputLive)
    else $error("slow power-down exit time wrong");

  a_bus_ack: assert property (
    busReq && !s_q.ack |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not single cycle");

  a_bit_advance: assert property (
    sShiftFall ##0 (s_q.bitCnt != LAST_BIT) |=> s_q.bitCnt == $past(s_q.bitCnt) + 5'h01)
    else $error("bit counter did not advance");

  a_idle_nofall: assert property (
    (s_q.st != ST_SHIFT) && sclkFall && !syncFall |=> $stable(s_q.shift) && $stable(s_q.code))
    else $error("clock edge outside frame was taken");

  a_held_ignore: assert property (
    (s_q.st == ST_HELD) && !syncFall |=> $stable(s_q.validCnt) && $stable(s_q.code))
    else $error("extra clock edge executed a frame");

  a_valid_count: assert property (
    commit |=> s_q.validCnt == $past(s_q.validCnt) + 8'h01)
    else $error("valid frame count wrong");

  a_abort_count: assert property (
    sFrameCut |=> s_q.abortCnt == $past(s_q.abortCnt) + 8'h01)
    else $error("aborted frame count wrong");

  a_mode_bits: assert property (
    commit |=> {pwr_mode_hi, pwr_mode_lo} == $past(nxtShift[MODE_HI_POS:MODE_LO_POS]))
    else $error("mode pins not loaded");

  a_code_out: assert property (
    commit |=> dacCode == $past(nxtShift[CODE_MSB:0]))
    else $error("code output not loaded");

  a_loaded_sticky: assert property (
    s_q.loaded |=> s_q.loaded)
    else $error("loaded flag dropped");

  a_hiz_open: assert property (
    (s_q.mode == MODE_PD_HIZ) |-> !term1k && !term100k && !ampConnect)
    else $error("open mode not open");

  a_pd_outputs: assert property (
    (s_q.mode != MODE_NORMAL) |-> !linearOn && !ampConnect && !outputLive)
    else $error("power-down left output live");

  a_wake_clear: assert property (
    commit && (newMode != MODE_NORMAL) |=> (s_q.wakeCnt == '0) && !outputLive)
    else $error("exit delay not cleared on power-down");

  a_bus_data: assert property (
    sBusTake |=> wb_dat_o == $past(rdMux))
    else $error("read data not registered");

  a_ack_idle: assert property (
    !busReq |=> !wb_ack_o)
    else $error("ack without request");

  a_ctrl_write: assert property (
    sCtrlWrite |=> s_q.lowSupply == $past(wb_dat_i[CTRL_LOWSUP_BIT]))
    else $error("supply select not written");

endmodule
`default_nettype wire

// >>> test/sdfc_host.sv
// serial master model driving frames into the converter link
`timescale 1ns/1ps
`default_nettype none
module sdfc_host (
  // clock
  input wire logic clk_sys,
  // serial link pins
  output logic frameSyncN,
  output logic serClk,
  output logic serDin
);
  initial begin
    frameSyncN = 1'b0;
    serClk = 1'b1;
    serDin = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // n falling edges; a short frame is cut off by raising sync
  task automatic send(input logic [23:0] f, input int n);
    frameSyncN <= 1'b1;
    tick(4);
    frameSyncN <= 1'b0;
    for (int i = 0; i < n; i++) begin
      serClk <= 1'b1;
      serDin <= f[23-i];
      tick(4);
      serClk <= 1'b0;
      tick(4);
    end
    serClk <= 1'b1;
    serDin <= ~serDin;
    // full frames leave sync idling low
    if (n < 24) begin
      frameSyncN <= 1'b1;
    end
    tick(8);
  endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench of the serial converter frame control
`timescale 1ns/1ps
`default_nettype none
module testbench import sdfc_pkg::*;;
  typedef struct packed {
    logic [23:0] f;
    logic [3:0] dec;
  } sdfc_row_t;

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [ADDR_W-1:0] wbAdr = 8'h00;
  logic [DATA_W-1:0] wbDatW = 32'h0000_0000;
  logic [3:0] wbSel = 4'h1;
  logic [DATA_W-1:0] wbDatR;
  logic [DATA_W-1:0] q;
  logic wbAck;
  logic [CODE_W-1:0] dacCode;
  logic pmHi, pmLo, linOn, ampOn, t1k, t100k, live;
  logic syncN, sclk, sdin;
  int err_count = 0;
  int compares = 0;
  // {linearOn, ampConnect, term1k, term100k} per mode
  sdfc_row_t rows [5] = '{'{24'hFC_1234, 4'hC}, '{24'h01_ABCD, 4'h2},
    '{24'h02_FFFF, 4'h1}, '{24'h03_0001, 4'h0}, '{24'h00_8000, 4'hC}};

  always #12.5 clk_sys = ~clk_sys;

  sdfc_host sdfc_host_i (.clk_sys(clk_sys), .frameSyncN(syncN), .serClk(sclk), .serDin(sdin));

  sdfc_top sdfc_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .frameSyncN(syncN),
    .serClk(sclk), .serDin(sdin), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .dacCode(dacCode), .pwr_mode_hi(pmHi), .pwr_mode_lo(pmLo),
    .linearOn(linOn), .ampConnect(ampOn), .term1k(t1k), .term100k(t100k),
    .outputLive(live));

  task automatic conclude();
    $display("errors %0d of %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    compares++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  // classic single cycle, entered just after a rising edge
  task automatic wb(input logic we, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    output logic [DATA_W-1:0] r);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    r = wbDatR;
    if (n >= 50) begin
      err_count++;
      conclude();
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk_sys);
  endtask

  initial begin
    #400us;
    err_count++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    chk("code after reset", 32'h0000_0000, 32'(dacCode));
    for (int i = 0; i < 5; i++) begin
      sdfc_host_i.send(rows[i].f, 24);
      chk("code", 32'(rows[i].f[15:0]), 32'(dacCode));
      chk("mode", 32'(rows[i].f[17:16]), 32'({pmHi, pmLo}));
      chk("decode", 32'(rows[i].dec), 32'({linOn, ampOn, t1k, t100k}));
      wb(1'b0, REG_CODE, 32'h0000_0000, q);
      chk("code reg", 32'(rows[i].f[15:0]), q);
    end
    chk("live early", 32'h0000_0000, 32'(live));
    repeat (70) @(posedge clk_sys);
    chk("live fast exit", 32'h0000_0000, 32'(live));
    repeat (40) @(posedge clk_sys);
    chk("live after fast exit", 32'h0000_0001, 32'(live));
    wb(1'b1, REG_CTRL, 32'h0000_0001, q);
    sdfc_host_i.send(24'h01_0000, 24);
    chk("code in power-down", 32'h0000_0000, 32'(dacCode));
    sdfc_host_i.send(24'h00_2222, 24);
    repeat (150) @(posedge clk_sys);
    chk("live slow exit", 32'h0000_0000, 32'(live));
    repeat (60) @(posedge clk_sys);
    chk("live after slow exit", 32'h0000_0001, 32'(live));
    sdfc_host_i.send(24'h03_5555, 10);
    chk("code kept", 32'h0000_2222, 32'(dacCode));
    chk("mode kept", 32'h0000_0000, 32'({pmHi, pmLo}));
    wb(1'b0, REG_STAT, 32'h0000_0000, q);
    chk("status", 32'h0001_0704, q);
    sdfc_host_i.send(24'h00_4321, 24);
    chk("code after abort", 32'h0000_4321, 32'(dacCode));
    wb(1'b0, 8'h10, 32'h0000_0000, q);
    chk("unmapped", 32'h0000_0000, q);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    chk("code after second reset", 32'h0000_0000, 32'(dacCode));
    wb(1'b0, REG_MODE, 32'h0000_0000, q);
    chk("mode reg", 32'h0000_0004, q);
    conclude();
  end
endmodule
`default_nettype wire
